// *** pkg/ring_msg_pkg.sv ***
// Constants, register map and helpers shared by the ring status messaging block
package ring_msg_pkg;

    // Clock and link rates
    localparam int unsigned CLK_HZ       = 125_000_000;
    localparam int unsigned RATE_LO_BPS  = 64_000;
    localparam int unsigned RATE_HI_BPS  = 128_000;
    localparam int unsigned BIT_DIV_W    = 11;
    localparam logic [BIT_DIV_W-1:0] BIT_DIV_LO = BIT_DIV_W'(CLK_HZ / RATE_LO_BPS);
    localparam logic [BIT_DIV_W-1:0] BIT_DIV_HI = BIT_DIV_W'(CLK_HZ / RATE_HI_BPS);
    localparam int unsigned MS_HZ        = 1_000;

    // Timing in milliseconds
    localparam int unsigned MS_W             = 12;
    localparam logic [MS_W-1:0] INTEG_MAX_MS = 12'd500;
    localparam logic [MS_W-1:0] INTEG_REQ_MS = 12'(INTEG_MAX_MS - 12'd1);
    localparam logic [MS_W-1:0] PEER_TO_MS   = 12'(4 * INTEG_MAX_MS);
    localparam logic [MS_W-1:0] RING_TO_MS   = 12'(4 * INTEG_MAX_MS);

    // Frame layout: start, sender id, states, parity, stop
    localparam int unsigned ID_W      = 4;
    localparam int unsigned STATE_W   = 16;
    localparam int unsigned FRAME_W   = ID_W + STATE_W;
    localparam int unsigned NUM_PEERS = 1 << ID_W;

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_STATES   = 8'h04;
    localparam logic [7:0] ADDR_RXSTATE  = 8'h08;
    localparam logic [7:0] ADDR_FLAGS    = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

    // Control field positions
    localparam int unsigned CTRL_EN_BIT    = 0;
    localparam int unsigned CTRL_DUAL_BIT  = 1;
    localparam int unsigned CTRL_RING_BIT  = 2;
    localparam int unsigned CTRL_FAST_BIT  = 3;
    localparam int unsigned CTRL_ID_LSB    = 8;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0008;
    localparam logic [STATE_W-1:0] STATES_RESET = 16'h0000;

    // Interrupt bit positions
    localparam int unsigned IRQ_W         = 3;
    localparam int unsigned IRQ_RING_BIT  = 0;
    localparam int unsigned IRQ_PEER_BIT  = 1;
    localparam int unsigned IRQ_RX_BIT    = 2;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

    function automatic logic frame_parity(input logic [FRAME_W-1:0] d);
        frame_parity = ^d;
    endfunction

endpackage : ring_msg_pkg

// *** rtl/ring_serial_tx.sv ***
// Frame serializer: start bit, data LSB first, even parity, stop bit
module ring_serial_tx import ring_msg_pkg::*; #(
    parameter int unsigned FW = FRAME_W
) (
    input  wire logic          ref_clk,
    input  wire logic          rstn,
    input  wire logic          bitEn,
    input  wire logic          load,
    input  wire logic [FW-1:0] frame,
    output logic               busy,
    output logic               txd
);
    localparam int unsigned SH_W = FW + 3;

    logic [SH_W-1:0] shift;
    logic [4:0]      bitsLeft;

    assign busy = (bitsLeft != 5'd0);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            shift    <= '1;
            bitsLeft <= 5'd0;
            txd      <= 1'b1;
        end else if (load && !busy) begin
            shift    <= {1'b1, frame_parity(frame), frame, 1'b0};
            bitsLeft <= 5'(SH_W);
        end else if (bitEn && busy) begin
            txd      <= shift[0];
            shift    <= {1'b1, shift[SH_W-1:1]};
            bitsLeft <= 5'(bitsLeft - 5'd1);
        end else if (bitEn) begin
            txd      <= 1'b1;
        end
    end
endmodule // ring_serial_tx

// *** rtl/ring_serial_rx.sv ***
// Frame deserializer with mid-bit sampling on the local bit period
module ring_serial_rx import ring_msg_pkg::*; #(
    parameter int unsigned FW = FRAME_W
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rstn,
    input  wire logic [BIT_DIV_W-1:0] bitPeriod,
    input  wire logic                 rxd,
    output logic                      frameValid,
    output logic [FW-1:0]             frameData
);
    logic                 busy;
    logic [BIT_DIV_W-1:0] cnt;
    logic [4:0]           bitIdx;
    logic [FW:0]          shift;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            busy       <= 1'b0;
            cnt        <= '0;
            bitIdx     <= 5'd0;
            shift      <= '0;
            frameValid <= 1'b0;
            frameData  <= '0;
        end else begin
            frameValid <= 1'b0;
            if (!busy) begin
                if (!rxd) begin
                    busy   <= 1'b1;
                    cnt    <= bitPeriod >> 1;
                    bitIdx <= 5'd0;
                end
            end else if (cnt != '0) begin
                cnt <= BIT_DIV_W'(cnt - 1'b1);
            end else begin
                cnt    <= BIT_DIV_W'(bitPeriod - 1'b1);
                bitIdx <= 5'(bitIdx + 5'd1);
                if (bitIdx == 5'd0) begin
                    // A glitch shorter than half a bit is not a start
                    busy <= !rxd;
                end else if (bitIdx == 5'(FW + 2)) begin
                    busy <= 1'b0;
                    if (rxd && (frame_parity(shift[FW-1:0]) == shift[FW])) begin
                        frameValid <= 1'b1;
                        frameData  <= shift[FW-1:0];
                    end
                end else begin
                    shift <= {rxd, shift[FW:1]};
                end
            end
        end
    end
endmodule // ring_serial_rx

// *** rtl/direct_status_ring.sv ***
// Peer-to-peer status messaging over one or two direct channels with APB registers
//
// Function
// - Two-channel card: each own message leaves on both channels together.
// - Single-channel card: own messages leave on channel zero only.
// - Received messages carrying another sender identifier are forwarded onward; the code drops one that arrives while its channel's forward slot is full.
// - Integrity message with current states goes out at most 500 ms apart.
// - A state change is sent at once unless the channel is still busy.
// - Ring mode: own messages must return, else raise ring-break flag.
// - Raise peer-offline flag when any known peer stops sending.
// - Every own message carries this device's sender identifier.
// - Link rate 64 or 128 kbps, one rate for both channels.
// - Per-hop delay stays well inside 0.2 cycle fast, 0.4 cycle slow.
//
// Decided for this implementation: the APB interface to the registers and the address map.
module direct_status_ring import ring_msg_pkg::*; #(
    parameter int unsigned MS_CYCLES = CLK_HZ / MS_HZ
) (
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rxd0,
    input  wire logic        rxd1,
    output logic             txd0,
    output logic             txd1,
    output logic             ringBreak,
    output logic             peerOffline,
    output logic             irq
);
    localparam int unsigned MS_DIV_W = $clog2(MS_CYCLES + 1);

    // Configuration and state registers
    logic                 enable;
    logic                 dualChan;
    logic                 ringMode;
    logic                 fastRate;
    logic [ID_W-1:0]      senderIdentifier;
    logic [STATE_W-1:0]   states;
    logic [STATE_W-1:0]   lastSent;
    logic [STATE_W-1:0]   rxStates;
    logic [ID_W-1:0]      rxSender;
    logic [IRQ_W-1:0]     irqStat;
    logic [IRQ_W-1:0]     irqMask;

    // Timing
    logic [BIT_DIV_W-1:0] bitPeriod;
    logic [BIT_DIV_W-1:0] bitCnt;
    logic                 bitEn;
    logic [MS_DIV_W-1:0]  msCnt;
    logic                 msTick;
    logic [MS_W-1:0]      integMs;
    logic [MS_W-1:0]      ringMs;

    // Channels
    logic [1:0]           txBusy;
    logic [1:0]           txLoad;
    logic [FRAME_W-1:0]   txFrame [2];
    logic [1:0]           rxValid;
    logic [FRAME_W-1:0]   rxFrame [2];
    logic [1:0]           fwdPend;
    logic [FRAME_W-1:0]   fwdFrame [2];
    logic [1:0]           chanOn;
    logic                 ownPend;
    logic                 ownLaunch;
    logic [1:0]           ownBack;

    // Peer supervision
    logic [NUM_PEERS-1:0] peerKnown;
    logic [MS_W-1:0]      peerMs [NUM_PEERS];
    logic [NUM_PEERS-1:0] peerLate;

    // APB
    logic                 apbWrite;
    logic                 apbRead;
    logic [31:0]          next_prdata;
    logic                 next_err;

    function automatic logic [ID_W-1:0] frame_sender(input logic [FRAME_W-1:0] f);
        frame_sender = f[ID_W-1:0];
    endfunction

    function automatic logic [MS_W-1:0] ms_step(input logic [MS_W-1:0] v);
        ms_step = (v == '1) ? v : MS_W'(v + 1'b1);
    endfunction

    // Bit rate divider, one rate for both channels
    assign bitPeriod = fastRate ? BIT_DIV_HI : BIT_DIV_LO;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            bitCnt <= '0;
            bitEn  <= 1'b0;
        end else if (bitCnt >= BIT_DIV_W'(bitPeriod - 1'b1)) begin
            bitCnt <= '0;
            bitEn  <= 1'b1;
        end else begin
            bitCnt <= BIT_DIV_W'(bitCnt + 1'b1);
            bitEn  <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            msCnt  <= '0;
            msTick <= 1'b0;
        end else if (msCnt == MS_DIV_W'(MS_CYCLES - 1)) begin
            msCnt  <= '0;
            msTick <= 1'b1;
        end else begin
            msCnt  <= MS_DIV_W'(msCnt + 1'b1);
            msTick <= 1'b0;
        end
    end

    // Channel one only carries traffic on a two-channel card
    assign chanOn = {dualChan, 1'b1};

    // Own message waits until every active transmitter is idle so both leave together
    assign ownLaunch = enable && ownPend && ((txBusy & chanOn) == 2'b00);

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            if (ownLaunch) begin
                txLoad[c]  = chanOn[c];
                txFrame[c] = {states, senderIdentifier};
            end else begin
                txLoad[c]  = enable && fwdPend[c] && chanOn[c] && !txBusy[c];
                txFrame[c] = fwdFrame[c];
            end
        end
    end

    ring_serial_tx #(.FW(FRAME_W)) u_tx0 (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .bitEn   (bitEn),
        .load    (txLoad[0]),
        .frame   (txFrame[0]),
        .busy    (txBusy[0]),
        .txd     (txd0)
    );

    ring_serial_tx #(.FW(FRAME_W)) u_tx1 (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .bitEn   (bitEn),
        .load    (txLoad[1]),
        .frame   (txFrame[1]),
        .busy    (txBusy[1]),
        .txd     (txd1)
    );

    ring_serial_rx #(.FW(FRAME_W)) u_rx0 (
        .ref_clk    (ref_clk),
        .rstn       (rstn),
        .bitPeriod  (bitPeriod),
        .rxd        (rxd0),
        .frameValid (rxValid[0]),
        .frameData  (rxFrame[0])
    );

    ring_serial_rx #(.FW(FRAME_W)) u_rx1 (
        .ref_clk    (ref_clk),
        .rstn       (rstn),
        .bitPeriod  (bitPeriod),
        .rxd        (rxd1),
        .frameValid (rxValid[1]),
        .frameData  (rxFrame[1])
    );

    // Own message request: on change or when the integrity interval runs out
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ownPend  <= 1'b0;
            lastSent <= STATES_RESET;
            integMs  <= '0;
        end else if (!enable) begin
            ownPend  <= 1'b0;
            integMs  <= '0;
        end else if (ownLaunch) begin
            ownPend  <= 1'b0;
            lastSent <= states;
            integMs  <= '0;
        end else begin
            if (states != lastSent) begin
                ownPend <= 1'b1;
            end
            if (integMs >= INTEG_REQ_MS) begin
                ownPend <= 1'b1;
            end
            if (msTick) begin
                integMs <= ms_step(integMs);
            end
        end
    end

    // Forwarding: one slot per channel, on the same direction it arrived from
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            fwdPend     <= 2'b00;
            fwdFrame[0] <= '0;
            fwdFrame[1] <= '0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (!enable || !chanOn[c]) begin
                    fwdPend[c] <= 1'b0;
                end else if (txLoad[c] && !ownLaunch) begin
                    fwdPend[c] <= 1'b0;
                end else if (rxValid[c] && !fwdPend[c]
                             && frame_sender(rxFrame[c]) != senderIdentifier) begin
                    // A full slot drops the new frame: bandwidth is exhausted
                    fwdPend[c]  <= 1'b1;
                    fwdFrame[c] <= rxFrame[c];
                end
            end
        end
    end

    // Own frames seen coming back around the ring
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            ownBack[c] = rxValid[c] && (frame_sender(rxFrame[c]) == senderIdentifier);
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ringMs    <= '0;
            ringBreak <= 1'b0;
        end else if (!enable || !ringMode) begin
            ringMs    <= '0;
            ringBreak <= 1'b0;
        end else begin
            if (ownBack != 2'b00) begin
                ringMs <= '0;
            end else if (msTick) begin
                ringMs <= ms_step(ringMs);
            end
            ringBreak <= (ringMs >= RING_TO_MS);
        end
    end

    // Last received states from any other sender
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rxStates <= '0;
            rxSender <= '0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (rxValid[c] && !ownBack[c]) begin
                    rxStates <= rxFrame[c][FRAME_W-1:ID_W];
                    rxSender <= frame_sender(rxFrame[c]);
                end
            end
        end
    end

    // Peer supervision, indexed by the sender identifier
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            peerKnown <= '0;
            for (int p = 0; p < NUM_PEERS; p++) begin
                peerMs[p] <= '0;
            end
        end else if (!enable) begin
            peerKnown <= '0;
        end else begin
            for (int p = 0; p < NUM_PEERS; p++) begin
                if ((rxValid[0] && !ownBack[0] && frame_sender(rxFrame[0]) == ID_W'(p))
                    || (rxValid[1] && !ownBack[1] && frame_sender(rxFrame[1]) == ID_W'(p)))
                begin
                    peerKnown[p] <= 1'b1;
                    peerMs[p]    <= '0;
                end else if (msTick) begin
                    peerMs[p]    <= ms_step(peerMs[p]);
                end
            end
        end
    end

    always_comb begin
        for (int p = 0; p < NUM_PEERS; p++) begin
            peerLate[p] = peerKnown[p] && (peerMs[p] >= PEER_TO_MS);
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            peerOffline <= 1'b0;
        end else begin
            peerOffline <= (peerLate != '0);
        end
    end

    // APB slave: one wait-free access phase, answer registered
    assign apbWrite = psel && penable && pwrite && pready;
    assign apbRead  = psel && !penable && !pwrite;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            enable           <= CTRL_RESET[CTRL_EN_BIT];
            dualChan         <= CTRL_RESET[CTRL_DUAL_BIT];
            ringMode         <= CTRL_RESET[CTRL_RING_BIT];
            fastRate         <= CTRL_RESET[CTRL_FAST_BIT];
            senderIdentifier <= CTRL_RESET[CTRL_ID_LSB +: ID_W];
            states           <= STATES_RESET;
            irqMask          <= IRQ_MASK_RESET;
        end else if (apbWrite) begin
            if (paddr == ADDR_CTRL) begin
                enable           <= pwdata[CTRL_EN_BIT];
                dualChan         <= pwdata[CTRL_DUAL_BIT];
                ringMode         <= pwdata[CTRL_RING_BIT];
                fastRate         <= pwdata[CTRL_FAST_BIT];
                senderIdentifier <= pwdata[CTRL_ID_LSB +: ID_W];
            end else if (paddr == ADDR_STATES) begin
                states           <= pwdata[STATE_W-1:0];
            end else if (paddr == ADDR_IRQ_MASK) begin
                irqMask          <= pwdata[IRQ_W-1:0];
            end
        end
    end

    // Sticky events; a new event in the clearing cycle survives the clear
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            irqStat <= '0;
        end else begin
            for (int b = 0; b < IRQ_W; b++) begin
                if (apbWrite && paddr == ADDR_IRQ_STAT && pwdata[b]) begin
                    irqStat[b] <= 1'b0;
                end
            end
            if (!ringBreak && enable && ringMode && ringMs >= RING_TO_MS) begin
                irqStat[IRQ_RING_BIT] <= 1'b1;
            end
            if (!peerOffline && peerLate != '0) begin
                irqStat[IRQ_PEER_BIT] <= 1'b1;
            end
            if ((rxValid & ~ownBack) != 2'b00) begin
                irqStat[IRQ_RX_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= ((irqStat & irqMask) != '0);
        end
    end

    always_comb begin
        next_prdata = 32'h0000_0000;
        next_err    = 1'b0;
        if (paddr == ADDR_CTRL) begin
            next_prdata[CTRL_EN_BIT]             = enable;
            next_prdata[CTRL_DUAL_BIT]           = dualChan;
            next_prdata[CTRL_RING_BIT]           = ringMode;
            next_prdata[CTRL_FAST_BIT]           = fastRate;
            next_prdata[CTRL_ID_LSB +: ID_W]     = senderIdentifier;
        end else if (paddr == ADDR_STATES) begin
            next_prdata[STATE_W-1:0]             = states;
        end else if (paddr == ADDR_RXSTATE) begin
            next_prdata[STATE_W-1:0]             = rxStates;
            next_prdata[STATE_W +: ID_W]         = rxSender;
        end else if (paddr == ADDR_FLAGS) begin
            next_prdata[0]                       = ringBreak;
            next_prdata[1]                       = peerOffline;
            next_prdata[31:16]                   = peerKnown & ~peerLate;
        end else if (paddr == ADDR_IRQ_STAT) begin
            next_prdata[IRQ_W-1:0]               = irqStat;
        end else if (paddr == ADDR_IRQ_MASK) begin
            next_prdata[IRQ_W-1:0]               = irqMask;
        end else begin
            next_err                             = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && next_err;
            if (apbRead) begin
                prdata <= next_prdata;
            end
        end
    end
endmodule // direct_status_ring

// *** testbench/direct_status_ring_asserts.sv ***
// Port-level checks for the ring status messaging block
module direct_status_ring_asserts import ring_msg_pkg::*; (
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        txd0,
    input wire logic        txd1,
    input wire logic        ringBreak,
    input wire logic        peerOffline,
    input wire logic        irq
);
    logic        dualSeen;
    logic        ring;
    logic [2:0]  mask;
    logic [15:0] lowRun;
    wire logic   wrHit = psel && penable && pready && pwrite;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // Shadows of the control and interrupt mask fields, taken from completed writes
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            dualSeen <= 1'b0;
            ring     <= 1'b0;
            mask     <= 3'h0;
        end else if (wrHit && paddr == ADDR_CTRL) begin
            dualSeen <= dualSeen | pwdata[CTRL_DUAL_BIT];
            ring     <= pwdata[CTRL_RING_BIT];
        end else if (wrHit && paddr == ADDR_IRQ_MASK) begin
            mask <= pwdata[2:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) lowRun <= 16'h0000;
        else lowRun <= txd0 ? 16'h0000 : 16'(lowRun + 16'h0001);
    end

    sequence setupPh;
        psel && !penable;
    endsequence
    sequence accessPh;
        psel && penable && pready;
    endsequence

    a_apb_answer: assert property (setupPh |=> accessPh)
        else $error("setup not answered in next cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_addr_err: assert property (pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > 8'h14))
        else $error("pslverr does not match address map");
    a_single_quiet: assert property (!dualSeen |-> txd1)
        else $error("second channel active on single channel card");
    a_ring_only: assert property (!ring && !$past(ring) |-> !ringBreak)
        else $error("ring break outside ring mode");
    a_bit_period: assert property ($rose(txd0) |-> lowRun % BIT_DIV_HI == 0)
        else $error("low run not a whole number of bits");
    a_break_irq: assert property ($rose(ringBreak) && mask[0] |-> ##[1:3] irq)
        else $error("ring break did not raise irq");
    a_offline_irq: assert property ($rose(peerOffline) && mask[1] |-> ##[1:3] irq)
        else $error("peer offline did not raise irq");
endmodule // direct_status_ring_asserts

bind direct_status_ring direct_status_ring_asserts direct_status_ring_asserts_inst (
    .ref_clk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .pslverr,
    .txd0, .txd1, .ringBreak, .peerOffline, .irq);

// *** testbench/ring_peer_model.sv ***
// Peer model that sends one status frame per request on its line
module ring_peer_model import ring_msg_pkg::*; (
    input  wire logic               ref_clk,
    input  wire logic               send,
    input  wire logic [ID_W-1:0]    id,
    input  wire logic [STATE_W-1:0] states,
    output logic                    txd
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        logic [22:0] bits;
        txd = 1'b1;
        forever begin
            @(posedge ref_clk);
            if (send) begin
                bits = {1'b1, ^{states, id}, states, id, 1'b0};
                for (int i = 0; i < 23; i++) begin
                    txd <= bits[i];
                    repeat (BIT_DIV_HI) @(posedge ref_clk);
                end
            end
        end
    end
endmodule // ring_peer_model

// *** testbench/direct_status_ring_tb_top.sv ***
// Self-checking bench for the ring status messaging block
module direct_status_ring_tb_top import ring_msg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MS = 50;
    localparam int BT = BIT_DIV_HI;
    logic        ref_clk = 1'b0;
    logic        rstn    = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata, r, seed = 32'h0000_00ba;
    logic        pready, pslverr, rxd0, txd0, txd1, ringBreak, peerOffline, irq, er;
    logic        send    = 1'b0;
    logic [15:0] peerSt  = 16'h0000;
    logic [21:0] f, g;
    int          n_fail = 0, cmp_count = 0, cyc = 0, tPeer;
    int          expQ[$];

    direct_status_ring #(.MS_CYCLES(MS)) direct_status_ring_inst (
        .ref_clk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .rxd0, .rxd1(1'b1), .txd0, .txd1, .ringBreak, .peerOffline, .irq);
    // Identifier 3 differs from the block's 5
    ring_peer_model ring_peer_model_inst (
        .ref_clk, .send, .id(4'h3), .states(peerSt), .txd(rxd0));

    initial forever #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;

    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) n_fail++;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] exp, string what);
        apb(1'b0, a, 32'h0000_0000);
        check(what, r, exp);
    endtask
    // Mid-bit sampling of both lines after a start edge on the first
    task automatic next_frame(string what);
        int n, e;
        n = 0;
        while (txd0 !== 1'b0 && n < 40000) begin
            @(negedge ref_clk);
            n++;
        end
        repeat (BT / 2) @(negedge ref_clk);
        for (int i = 0; i < 22; i++) begin
            repeat (BT) @(negedge ref_clk);
            f[i] = txd0;
            g[i] = txd1;
        end
        e = expQ.pop_front();
        check(what, 32'(f), 32'({1'b1, ^e[19:0], e[19:0]}));
    endtask
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(ADDR_CTRL, CTRL_RESET, "ctrl");
        rd(ADDR_STATES, 32'h0000_0000, "states");
        rd(ADDR_IRQ_MASK, 32'h0000_0000, "mask");
        apb(1'b0, 8'h40, 32'h0000_0000);
        check("unmapped", {31'h0, er}, 32'h0000_0001);
        check("idle lines", {30'h0, txd0, txd1}, 32'h0000_0003);
        seed = lfsr(seed);
        apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0007);
        apb(1'b1, ADDR_STATES, seed);
        apb(1'b1, ADDR_CTRL, 32'h0000_050F);
        expQ.push_back({seed[15:0], 4'h5});
        seed = lfsr(seed);
        peerSt <= seed[15:0];
        send <= 1'b1;
        @(posedge ref_clk);
        send <= 1'b0;
        tPeer = cyc + 23 * BT;
        expQ.push_back({seed[15:0], 4'h3});
        expQ.push_back(expQ[0]);
        next_frame("own frame");
        check("second channel", 32'(g), 32'(f));
        next_frame("forwarded");
        rd(ADDR_RXSTATE, {12'h000, 4'h3, peerSt}, "rx state");
        rd(ADDR_IRQ_STAT, 32'h0000_0004, "rx event");
        check("irq", {31'h0, irq}, 32'h0000_0001);
        apb(1'b1, ADDR_IRQ_STAT, 32'h0000_0004);
        seed = lfsr(seed);
        apb(1'b1, ADDR_STATES, seed);
        check("irq clear", {31'h0, irq}, 32'h0000_0000);
        expQ.push_back({seed[15:0], 4'h5});
        next_frame("integrity");
        next_frame("changed states");
        while (cyc < tPeer + int'(PEER_TO_MS) * MS - 2 * BT) @(posedge ref_clk);
        check("early offline", {31'h0, peerOffline}, 32'h0000_0000);
        repeat (4 * BT) @(posedge ref_clk);
        rd(ADDR_FLAGS, 32'h0000_0003, "flags");
        rd(ADDR_IRQ_STAT, 32'h0000_0003, "flag events");
        apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0000);
        apb(1'b1, ADDR_CTRL, 32'h0000_0000);
        check("irq masked", {31'h0, irq}, 32'h0000_0000);
        repeat (3) @(posedge ref_clk);
        check("flags off", {30'h0, ringBreak, peerOffline}, 32'h0000_0000);
        final_report();
    end

    // Run needs about 125k cycles
    initial begin
        repeat (200000) @(posedge ref_clk);
        n_fail++;
        final_report();
    end
endmodule // direct_status_ring_tb_top
